// ===== hdl/dcdcr_regs.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RULE1: coarse 6-bit, fine 8-bit, phase 5-bit readbacks are read-only, zero after reset.
// RULE2: readbacks refresh only on a zero-to-one change of the request bit.
// RULE3: clock invert bit 0 passes loop clock normally, 1 inverts it.
// RULE4: duty cycle correction on while control bit 1 set; set after reset.
// RULE5: cross control on while control bit 0 set; set after reset.
// RULE6: loop clock reaches test output only while debug bit 7 set; clear at reset.
// RULE7: 2-bit debug field selects test clock divide ratio; resets to zero.
// RULE8: software changes 4-bit lane count, reset 8, only during deframer soft reset; the code takes lane writes at any time.
// RULE9: datapath bit 7 enables inverse sinc filter, zero bypasses it; reset zero.
// RULE10: 4-bit ratio select resets to 1; undefined codes force safe bypass.
// RULE11: reserved bits read zero; writes to reserved and read-only bits ignored.
module dcdcr_regs (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // delay loop setpoints and request level
  input wire logic [5:0] dll_coarse_in,
  input wire logic [7:0] dll_fine_in,
  input wire logic [4:0] dll_phase_in,
  input wire logic readback_request,
  input wire logic dll_clk,
  // clock controls
  output logic clock_polarity_invert,
  output logic duty_correction_enable,
  output logic cross_control_enable,
  output logic test_clk_out,
  // datapath controls
  output logic [3:0] serial_lane_count,
  output logic [3:0] upsample_ratio_select,
  output logic interp_reserved,
  output logic sinc_compensation_enable
);

  typedef struct packed {
    logic [5:0] coarse;
    logic [7:0] fine;
    logic [4:0] phase;
    logic req_q;
    logic inv;
    logic dcc;
    logic xc;
    logic test_en;
    logic [1:0] test_div;
    logic [3:0] lanes;
    logic [3:0] interp_raw;
    logic [3:0] interp_eff;
    logic interp_rsv;
    logic sinc;
    logic [7:0] rdata;
    logic rvalid;
  } dcdcr_regs_t;

  localparam dcdcr_regs_t ST_RST = '{
    coarse: dcdcr_pkg::COARSE_RST,
    fine: dcdcr_pkg::FINE_RST,
    phase: dcdcr_pkg::PHASE_RST,
    req_q: 1'b0,
    inv: dcdcr_pkg::CLK_INV_RST,
    dcc: dcdcr_pkg::DCC_RST,
    xc: dcdcr_pkg::XC_RST,
    test_en: dcdcr_pkg::TEST_EN_RST,
    test_div: dcdcr_pkg::TEST_DIV_RST,
    lanes: dcdcr_pkg::LANES_RST,
    interp_raw: dcdcr_pkg::INTERP_RST,
    interp_eff: dcdcr_pkg::INTERP_RST,
    interp_rsv: 1'b0,
    sinc: dcdcr_pkg::SINC_RST,
    rdata: dcdcr_pkg::RD_ZERO,
    rvalid: 1'b0
  };

  dcdcr_regs_t st_r;
  dcdcr_regs_t st_nxt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // codes above the last defined ratio are reserved
  function automatic logic interp_valid(input logic [3:0] code);
    interp_valid = (code <= dcdcr_pkg::INTERP_MAX);
  endfunction : interp_valid

  // RULE1: readback words, upper bits zero
  // read mux; unmapped offsets and reserved bits answer zero
  function automatic logic [7:0] read_word(input logic [11:0] addr,
                                           input dcdcr_regs_t s);
    logic [7:0] w;
    w = dcdcr_pkg::RD_ZERO;
    case (addr)
      dcdcr_pkg::COARSE_RB_ADDR: w[5:0] = s.coarse;
      dcdcr_pkg::FINE_RB_ADDR: w = s.fine;
      dcdcr_pkg::PHASE_RB_ADDR: w[4:0] = s.phase;
      dcdcr_pkg::CLK_CTRL_ADDR:
      begin
        w[dcdcr_pkg::CLK_INV_BIT] = s.inv;
        w[dcdcr_pkg::DCC_BIT] = s.dcc;
        w[dcdcr_pkg::XC_BIT] = s.xc;
      end
      dcdcr_pkg::TEST_OUT_ADDR:
      begin
        w[dcdcr_pkg::TEST_EN_BIT] = s.test_en;
        w[dcdcr_pkg::TEST_DIV_LSB +: 2] = s.test_div;
      end
      dcdcr_pkg::LANE_INTERP_ADDR:
      begin
        w[dcdcr_pkg::LANES_LSB +: 4] = s.lanes;
        w[dcdcr_pkg::INTERP_LSB +: 4] = s.interp_raw;
      end
      dcdcr_pkg::DATAPATH_ADDR: w[dcdcr_pkg::SINC_BIT] = s.sinc;
      default: w = dcdcr_pkg::RD_ZERO;
    endcase
    read_word = w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.req_q = readback_request;
    // RULE2: capture on request rising only
    if (readback_request && !st_r.req_q)
    begin
      st_nxt.coarse = dll_coarse_in;
      st_nxt.fine = dll_fine_in;
      st_nxt.phase = dll_phase_in;
    end
    // RULE11: writes touch writable bits only
    if (reg_wr)
    begin
      case (reg_addr)
        dcdcr_pkg::CLK_CTRL_ADDR:
        begin
          st_nxt.inv = reg_wdata[dcdcr_pkg::CLK_INV_BIT];
          st_nxt.dcc = reg_wdata[dcdcr_pkg::DCC_BIT];
          st_nxt.xc = reg_wdata[dcdcr_pkg::XC_BIT];
        end
        dcdcr_pkg::TEST_OUT_ADDR:
        begin
          st_nxt.test_en = reg_wdata[dcdcr_pkg::TEST_EN_BIT];
          st_nxt.test_div = reg_wdata[dcdcr_pkg::TEST_DIV_LSB +: 2];
        end
        dcdcr_pkg::LANE_INTERP_ADDR:
        begin
          // RULE8: lane count taken as is, no resync
          st_nxt.lanes = reg_wdata[dcdcr_pkg::LANES_LSB +: 4];
          st_nxt.interp_raw = reg_wdata[dcdcr_pkg::INTERP_LSB +: 4];
        end
        dcdcr_pkg::DATAPATH_ADDR:
          st_nxt.sinc = reg_wdata[dcdcr_pkg::SINC_BIT];
        default: ;
      endcase
    end
    // RULE10: reserved ratio codes fall back to bypass
    if (interp_valid(st_nxt.interp_raw))
    begin
      st_nxt.interp_eff = st_nxt.interp_raw;
      st_nxt.interp_rsv = 1'b0;
    end
    else
    begin
      st_nxt.interp_eff = dcdcr_pkg::INTERP_BYPASS;
      st_nxt.interp_rsv = 1'b1;
    end
    // read answer one cycle later, old value if written same cycle
    st_nxt.rvalid = reg_rd;
    st_nxt.rdata = reg_rd ? read_word(reg_addr, st_r) : dcdcr_pkg::RD_ZERO;
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= ST_RST;
    else if (clk_en)
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // test clock divider
  // ----------------------------------------------------------------
  dcdcr_tclk_if tif ();

  assign tif.clk_en = clk_en;
  assign tif.enable = st_r.test_en;
  assign tif.div_sel = st_r.test_div;

  dcdcr_test_clk_div u_div (
    .clk_sys (clk_sys),
    .rst_b (rst_b),
    .dll_clk (dll_clk),
    .tif (tif)
  );

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  // RULE3: polarity control to the clock path
  assign clock_polarity_invert = st_r.inv;
  // RULE4: duty correction control
  assign duty_correction_enable = st_r.dcc;
  // RULE5: cross control enable
  assign cross_control_enable = st_r.xc;
  // RULE9: sinc compensation enable
  assign sinc_compensation_enable = st_r.sinc;
  assign test_clk_out = tif.out;
  assign serial_lane_count = st_r.lanes;
  assign upsample_ratio_select = st_r.interp_eff;
  assign interp_reserved = st_r.interp_rsv;
  assign reg_rdata = st_r.rdata;
  assign reg_rd_valid = st_r.rvalid;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  coarse_read_a: assert property ( // RULE1
    @(posedge clk_sys) disable iff (!rst_b)
    clk_en && reg_rd && reg_addr == dcdcr_pkg::COARSE_RB_ADDR
    |=> reg_rd_valid && reg_rdata == {2'h0, $past(st_r.coarse)})
    else $error("coarse readback answer wrong");

  rb_hold_a: assert property ( // RULE2
    @(posedge clk_sys) disable iff (!rst_b)
    !(clk_en && readback_request && !st_r.req_q)
    |=> $stable(st_r.coarse) && $stable(st_r.fine) && $stable(st_r.phase))
    else $error("readback changed without request edge");

  rb_capture_a: assert property ( // RULE2
    @(posedge clk_sys) disable iff (!rst_b)
    clk_en && readback_request && !st_r.req_q
    |=> st_r.fine == $past(dll_fine_in) && st_r.phase == $past(dll_phase_in)
        && st_r.coarse == $past(dll_coarse_in))
    else $error("readback not captured on request");

  polarity_wr_a: assert property ( // RULE3
    @(posedge clk_sys) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == dcdcr_pkg::CLK_CTRL_ADDR
    |=> clock_polarity_invert == $past(reg_wdata[dcdcr_pkg::CLK_INV_BIT]))
    else $error("clock invert not written");

  duty_cross_a: assert property ( // RULE4
    @(posedge clk_sys) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == dcdcr_pkg::CLK_CTRL_ADDR
    |=> duty_correction_enable == $past(reg_wdata[dcdcr_pkg::DCC_BIT])
        && cross_control_enable == $past(reg_wdata[dcdcr_pkg::XC_BIT]))
    else $error("duty or cross control not written");

  cross_hold_a: assert property ( // RULE5
    @(posedge clk_sys) disable iff (!rst_b)
    !(reg_wr && reg_addr == dcdcr_pkg::CLK_CTRL_ADDR)
    |=> $stable(cross_control_enable))
    else $error("cross control moved without write");

  sinc_wr_a: assert property ( // RULE9
    @(posedge clk_sys) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == dcdcr_pkg::DATAPATH_ADDR
    |=> sinc_compensation_enable == $past(reg_wdata[dcdcr_pkg::SINC_BIT]))
    else $error("sinc enable not written");

  interp_safe_a: assert property ( // RULE10
    @(posedge clk_sys) disable iff (!rst_b)
    interp_reserved == (st_r.interp_raw > dcdcr_pkg::INTERP_MAX)
    && (interp_reserved ? upsample_ratio_select == dcdcr_pkg::INTERP_BYPASS
                        : upsample_ratio_select == st_r.interp_raw))
    else $error("ratio select not made safe");

  reserved_zero_a: assert property ( // RULE11
    @(posedge clk_sys) disable iff (!rst_b)
    clk_en && reg_rd && reg_addr == dcdcr_pkg::PHASE_RB_ADDR
    |=> reg_rdata[7:5] == 3'h0)
    else $error("reserved bits read nonzero");

endmodule : dcdcr_regs

`default_nettype wire

// ===== hdl/dcdcr_pkg.sv
`default_nettype none

package dcdcr_pkg;

  // ----------------------------------------------------------------
  // register port widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] COARSE_RB_ADDR = 12'h099;
  localparam logic [11:0] FINE_RB_ADDR = 12'h09a;
  localparam logic [11:0] PHASE_RB_ADDR = 12'h09b;
  localparam logic [11:0] CLK_CTRL_ADDR = 12'h09d;
  localparam logic [11:0] TEST_OUT_ADDR = 12'h0a0;
  localparam logic [11:0] LANE_INTERP_ADDR = 12'h110;
  localparam logic [11:0] DATAPATH_ADDR = 12'h111;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int COARSE_W = 6;
  localparam int FINE_W = 8;
  localparam int PHASE_W = 5;
  localparam int CLK_INV_BIT = 2;
  localparam int DCC_BIT = 1;
  localparam int XC_BIT = 0;
  localparam int TEST_EN_BIT = 7;
  localparam int TEST_DIV_LSB = 0;
  localparam int LANES_LSB = 4;
  localparam int INTERP_LSB = 0;
  localparam int SINC_BIT = 7;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [5:0] COARSE_RST = 6'h00;
  localparam logic [7:0] FINE_RST = 8'h00;
  localparam logic [4:0] PHASE_RST = 5'h00;
  localparam logic CLK_INV_RST = 1'b0;
  localparam logic DCC_RST = 1'b1;
  localparam logic XC_RST = 1'b1;
  localparam logic TEST_EN_RST = 1'b0;
  localparam logic [1:0] TEST_DIV_RST = 2'h0;
  localparam logic [3:0] LANES_RST = 4'h8;
  localparam logic [3:0] INTERP_RST = 4'h1;
  localparam logic SINC_RST = 1'b0;
  localparam logic [3:0] INTERP_MAX = 4'h8;
  localparam logic [3:0] INTERP_BYPASS = 4'h0;
  localparam logic [7:0] RD_ZERO = 8'h00;

endpackage : dcdcr_pkg

`default_nettype wire

// ===== hdl/dcdcr_tclk_if.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// test clock divider control
// ------------------------------------------------------------------
interface dcdcr_tclk_if;
  logic clk_en;
  logic enable;
  logic [1:0] div_sel;
  logic out;

  modport cfg (output clk_en, output enable, output div_sel, input out);
  modport div (input clk_en, input enable, input div_sel, output out);
endinterface : dcdcr_tclk_if

`default_nettype wire

// ===== hdl/dcdcr_test_clk_div.sv
`timescale 1ns/10ps
`default_nettype none

module dcdcr_test_clk_div (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // loop clock pin, asynchronous
  input wire logic dll_clk,
  // control from the register slice
  dcdcr_tclk_if.div tif
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic [2:0] cnt;
    logic out;
  } dcdcr_div_t;

  dcdcr_div_t st_r;
  dcdcr_div_t st_nxt;
  logic rise;
  logic [2:0] half_m1;

  // ----------------------------------------------------------------
  // sampling and division
  // ----------------------------------------------------------------
  // s1 feeds s2 only; a level counts once s2 and s3 agree
  always_comb
  begin
    st_nxt = st_r;
    rise = 1'b0;
    st_nxt.s1 = dll_clk;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3 && st_r.s3 != st_r.lvl)
    begin
      st_nxt.lvl = st_r.s3;
      rise = st_r.s3;
    end
    case (tif.div_sel)
      2'h2: half_m1 = 3'h1;
      2'h3: half_m1 = 3'h3;
      default: half_m1 = 3'h0;
    endcase
    // RULE6: output gated by enable
    if (!tif.enable)
    begin
      st_nxt.cnt = 3'h0;
      st_nxt.out = 1'b0;
    end
    // RULE7: ratio one passes the level, else 2**sel
    else if (tif.div_sel == 2'h0)
    begin
      st_nxt.out = st_r.lvl;
    end
    else if (rise)
    begin
      if (st_r.cnt >= half_m1)
      begin
        st_nxt.cnt = 3'h0;
        st_nxt.out = ~st_r.out;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt + 3'h1;
      end
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else if (tif.clk_en)
      st_r <= st_nxt;
  end

  assign tif.out = st_r.out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  test_gate_off_a: assert property ( // RULE6
    @(posedge clk_sys) disable iff (!rst_b)
    tif.clk_en && !tif.enable |=> !st_r.out)
    else $error("test clock not gated off");

  div_one_pass_a: assert property ( // RULE7
    @(posedge clk_sys) disable iff (!rst_b)
    tif.clk_en && tif.enable && tif.div_sel == 2'h0
    |=> st_r.out == $past(st_r.lvl))
    else $error("undivided test clock wrong");

  div_hold_a: assert property ( // RULE7
    @(posedge clk_sys) disable iff (!rst_b)
    tif.clk_en && tif.enable && tif.div_sel != 2'h0 && !rise
    |=> $stable(st_r.out))
    else $error("divided clock moved without edge");

endmodule : dcdcr_test_clk_div

`default_nettype wire

// ===== test/dcdcr_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none

module dcdcr_regs_tb;
  logic clk_sys;
  logic rst_b;
  logic clk_en;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_rd_valid;
  logic [5:0] dll_coarse_in;
  logic [7:0] dll_fine_in;
  logic [4:0] dll_phase_in;
  logic readback_request;
  logic dll_clk;
  logic clock_polarity_invert;
  logic duty_correction_enable;
  logic cross_control_enable;
  logic test_clk_out;
  logic [3:0] serial_lane_count;
  logic [3:0] upsample_ratio_select;
  logic interp_reserved;
  logic sinc_compensation_enable;
  int fails;
  int n_checks;
  int cnt;

  dcdcr_regs DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .dll_coarse_in(dll_coarse_in), .dll_fine_in(dll_fine_in),
    .dll_phase_in(dll_phase_in), .readback_request(readback_request),
    .dll_clk(dll_clk), .clock_polarity_invert(clock_polarity_invert),
    .duty_correction_enable(duty_correction_enable),
    .cross_control_enable(cross_control_enable),
    .test_clk_out(test_clk_out), .serial_lane_count(serial_lane_count),
    .upsample_ratio_select(upsample_ratio_select),
    .interp_reserved(interp_reserved),
    .sinc_compensation_enable(sinc_compensation_enable)
  );

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  // free running system clock, 10 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // whole run is about a thousand cycles; 100 us means a hang
  initial
  begin
    #100us;
    fails++;
    conclude();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string msg);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg,
               seen, exp);
    end
  endtask : chk

  // one write strobe, outputs settled when this returns
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // read strobe; data and valid stand just after the taking edge
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e, "read data");
    chk({7'h00, reg_rd_valid}, 8'h01, "read valid");
  endtask : rd

  // count rising edges of the test output over 16 loop clock periods
  task automatic tcount(output int n);
    logic prev;
    n = 0;
    prev = test_clk_out;
    for (int i = 0; i < 160; i++)
    begin
      @(posedge clk_sys);
      if (i % 5 == 0)
        dll_clk <= ~dll_clk;
      #1;
      if (test_clk_out && !prev)
        n++;
      prev = test_clk_out;
    end
  endtask : tcount

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    fails = 0;
    n_checks = 0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dll_coarse_in = 6'h00;
    dll_fine_in = 8'h00;
    dll_phase_in = 5'h00;
    readback_request = 1'b0;
    dll_clk = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    // reset values at the pins and through the register port
    chk({5'h00, clock_polarity_invert, duty_correction_enable,
         cross_control_enable}, 8'h03, "clock controls");
    chk({4'h0, serial_lane_count}, 8'h08, "lane count");
    chk({4'h0, upsample_ratio_select}, 8'h01, "ratio");
    chk({7'h00, sinc_compensation_enable}, 8'h00, "sinc");
    chk({7'h00, test_clk_out}, 8'h00, "test clock");
    rd(dcdcr_pkg::COARSE_RB_ADDR, 8'h00);
    rd(dcdcr_pkg::FINE_RB_ADDR, 8'h00);
    rd(dcdcr_pkg::PHASE_RB_ADDR, 8'h00);
    rd(dcdcr_pkg::CLK_CTRL_ADDR, 8'h03);
    rd(dcdcr_pkg::TEST_OUT_ADDR, 8'h00);
    rd(dcdcr_pkg::LANE_INTERP_ADDR, 8'h81);
    rd(dcdcr_pkg::DATAPATH_ADDR, 8'h00);
    // unmapped place, then valid drops after one cycle
    rd(12'h0ff, 8'h00);
    @(posedge clk_sys);
    #1;
    chk({7'h00, reg_rd_valid}, 8'h00, "valid drop");
    // clock controls: reserved bits dropped, then walk value
    wr(dcdcr_pkg::CLK_CTRL_ADDR, 8'hff);
    rd(dcdcr_pkg::CLK_CTRL_ADDR, 8'h07);
    wr(dcdcr_pkg::CLK_CTRL_ADDR, 8'h04);
    chk({5'h00, clock_polarity_invert, duty_correction_enable,
         cross_control_enable}, 8'h04, "clock controls");
    rd(dcdcr_pkg::CLK_CTRL_ADDR, 8'h04);
    // capture on the rising edge of the request only
    @(posedge clk_sys);
    dll_coarse_in <= 6'h3f;
    dll_fine_in <= 8'ha5;
    dll_phase_in <= 5'h1f;
    readback_request <= 1'b1;
    rd(dcdcr_pkg::COARSE_RB_ADDR, 8'h3f);
    rd(dcdcr_pkg::FINE_RB_ADDR, 8'ha5);
    rd(dcdcr_pkg::PHASE_RB_ADDR, 8'h1f);
    @(posedge clk_sys);
    dll_fine_in <= 8'h11;
    dll_coarse_in <= 6'h05;
    rd(dcdcr_pkg::FINE_RB_ADDR, 8'ha5);
    @(posedge clk_sys);
    readback_request <= 1'b0;
    @(posedge clk_sys);
    readback_request <= 1'b1;
    rd(dcdcr_pkg::FINE_RB_ADDR, 8'h11);
    wr(dcdcr_pkg::FINE_RB_ADDR, 8'h00);
    rd(dcdcr_pkg::FINE_RB_ADDR, 8'h11);
    rd(dcdcr_pkg::COARSE_RB_ADDR, 8'h05);
    // every ratio code, reserved codes fall back to bypass
    for (int c = 0; c < 16; c++)
    begin
      wr(dcdcr_pkg::LANE_INTERP_ADDR, {4'h3, c[3:0]});
      chk({4'h0, upsample_ratio_select}, (c <= 8) ? c[7:0] : 8'h00,
          "ratio");
      chk({7'h00, interp_reserved}, {7'h00, c > 8}, "reserved");
      chk({4'h0, serial_lane_count}, 8'h03, "lane count");
      rd(dcdcr_pkg::LANE_INTERP_ADDR, {4'h3, c[3:0]});
    end
    // datapath filter enable and its reserved bits
    wr(dcdcr_pkg::DATAPATH_ADDR, 8'hff);
    chk({7'h00, sinc_compensation_enable}, 8'h01, "sinc");
    rd(dcdcr_pkg::DATAPATH_ADDR, 8'h80);
    wr(dcdcr_pkg::DATAPATH_ADDR, 8'h00);
    chk({7'h00, sinc_compensation_enable}, 8'h00, "sinc");
    // a write while the clock enable is low is frozen out
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(dcdcr_pkg::DATAPATH_ADDR, 8'h80);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(dcdcr_pkg::DATAPATH_ADDR, 8'h00);
    // test output: disabled keeps it low, then each divide ratio
    wr(dcdcr_pkg::TEST_OUT_ADDR, 8'h03);
    tcount(cnt);
    chk(cnt[7:0], 8'h00, "test clock off");
    wr(dcdcr_pkg::TEST_OUT_ADDR, 8'hff);
    rd(dcdcr_pkg::TEST_OUT_ADDR, 8'h83);
    // edges are counted with one of slack for the divider phase
    for (int s = 0; s < 4; s++)
    begin
      wr(dcdcr_pkg::TEST_OUT_ADDR, {6'h20, s[1:0]});
      tcount(cnt);
      chk({7'h00, cnt >= (16 >> s) - 1 && cnt <= (16 >> s) + 1}, 8'h01,
          "divided edges");
    end
    // undivided output follows a held high level, so gating is visible
    wr(dcdcr_pkg::TEST_OUT_ADDR, 8'h80);
    @(posedge clk_sys);
    dll_clk <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    chk({7'h00, test_clk_out}, 8'h01, "test clock level");
    wr(dcdcr_pkg::TEST_OUT_ADDR, 8'h00);
    @(posedge clk_sys);
    #1;
    chk({7'h00, test_clk_out}, 8'h00, "test clock off");
    // mid-run reset; request dropped or release would capture again
    @(posedge clk_sys);
    rst_b <= 1'b0;
    readback_request <= 1'b0;
    dll_clk <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(dcdcr_pkg::COARSE_RB_ADDR, 8'h00);
    rd(dcdcr_pkg::FINE_RB_ADDR, 8'h00);
    rd(dcdcr_pkg::CLK_CTRL_ADDR, 8'h03);
    conclude();
  end
endmodule : dcdcr_regs_tb

`default_nettype wire
